// ### inc/tbc_pkg.sv
// constants for the trigger and busy control register group
package tbc_pkg;
	localparam logic [7:0] A_BUSY = 8'h28;
	localparam logic [7:0] A_CLK = 8'h2C;
	localparam logic [7:0] A_PRESC = 8'h30;
	localparam logic [7:0] A_BLOCK = 8'h34;
	localparam logic [7:0] A_RULES = 8'h38;
	localparam logic [7:0] A_COIN = 8'h3C;
	localparam logic [7:0] A_CODE_EN = 8'h44;
	localparam logic [7:0] A_GEN_EN = 8'h48;
	localparam logic [7:0] A_IRQBLK = 8'h4C;
	localparam logic [7:0] A_SYNC = 8'h50;
	localparam logic [7:0] A_RC_LO = 8'h54;
	localparam logic [7:0] A_RC_HI = 8'h58;
	localparam logic [7:0] A_CAP_HI = 8'h60;
	localparam logic [7:0] A_GEN_PS = 8'h64;
	localparam logic [7:0] A_CAP_ST = 8'h68;
	localparam logic [7:0] A_CAP_MID = 8'h6C;
	localparam logic [7:0] A_CAP_UP = 8'h70;
	localparam logic [1:0] CLK_SEL_RST = 2'h0;
	localparam logic [1:0] CLK_SEL_FIBRE1 = 2'h2;
	localparam logic [3:0] BRIDGE_KEY = 4'h5;
	localparam logic [3:0] SUPER_KEY = 4'h7;
	localparam logic [2:0] MUL_KEY = 3'h5;
	localparam logic [7:0] BLK_THR_RST = 8'h01;
	localparam logic [7:0] RULE_RST = 8'h03;
	localparam logic [7:0] COIN_RST = 8'h01;
	localparam logic [7:0] INH_RST = 8'h00;
	localparam logic [4:0] EVT_SAT = 5'h1F;
	localparam logic [7:0] EVT_LIMIT = 8'h1E;
	localparam logic [2:0] IRQ_SAT = 3'h7;
	localparam logic [7:0] IRQ_LIMIT = 8'h06;
	localparam logic [3:0] CAP_PATTERN = 4'h6;
	localparam int CAP_DEPTH = 1024;
	localparam int CAP_AW = 10;
	localparam logic [15:0] CLK_NS = 16'h0032;
	localparam logic [15:0] RULE_FINE_NS = 16'h0010;
	localparam logic [15:0] RULE_COARSE_NS = 16'h01F4;
	localparam logic [15:0] SEC_OFFSET_NS = 16'h0A28;
	localparam logic [15:0] SEC_STEP_NS = 16'h0004;
	localparam int SUPER_PULSE_NS = 20;
	localparam int SUPER_PULSE_CYC = (SUPER_PULSE_NS / 50 < 1) ? 1 : SUPER_PULSE_NS / 50;
	typedef enum logic [2:0] {
		CAP_ARM  = 3'b001,
		CAP_FILL = 3'b010,
		CAP_DONE = 3'b100
	} tbc_cap_t;
endpackage

// ### design/tbc_regs.sv
// trigger, busy and debug-capture control register group
module tbc_regs
	import tbc_pkg::*;
(
	// clock and reset
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	// register port
	input  wire logic [7:0]   i_reg_addr,
	input  wire logic         i_reg_wr,
	input  wire logic         i_reg_rd,
	input  wire logic [31:0]  i_reg_wdata,
	output logic      [31:0]  o_reg_rdata,
	output logic              o_reg_ack,
	// busy sources and output
	input  wire logic [6:0]   i_busy_pins,
	input  wire logic [7:0]   i_fibre_busy,
	input  wire logic [7:0]   i_fibre_loss,
	input  wire logic         i_fibre_ack,
	output logic              o_busy,
	// triggers
	input  wire logic         i_trig_in,
	input  wire logic         i_trig_panel,
	input  wire logic         i_secondary_trig,
	output logic              o_primary_trig,
	output logic              o_secondary_trig,
	// clock and mode
	output logic      [1:0]   o_clk_sel,
	output logic              o_bridge_mode,
	output logic              o_supervisor_mode,
	// block and status inputs
	input  wire logic         i_block_formed,
	input  wire logic         i_block_read,
	input  wire logic [7:0]   i_event_count,
	input  wire logic [7:0]   i_irq_waiting,
	input  wire logic         i_fifo_dropped,
	input  wire logic         i_run_stopped,
	input  wire logic         i_fill_active,
	input  wire logic         i_sync_reset_req,
	input  wire logic         i_sync_event_busy,
	// sync delay
	input  wire logic [7:0]   i_sync_phase1,
	input  wire logic [7:0]   i_sync_phase5,
	output logic      [7:0]   o_sync_delay_fibre1,
	output logic      [7:0]   o_sync_delay_loop,
	output logic      [7:0]   o_sync_delay_fibre5,
	// readout controllers
	input  wire logic         i_rc_sent,
	input  wire logic [7:0]   i_rc_ack,
	// front panel
	output logic      [3:0]   o_panel_out,
	output logic      [5:0]   o_panel_code_en,
	output logic      [15:0]  o_panel_generic_en,
	output logic      [23:0]  o_panel_generic_prescale,
	// debug capture channels
	input  wire logic [127:0] i_cap_ch
);
	import tbc_pkg::*;

	function automatic logic [15:0] win_ns(input logic [7:0] r);
		win_ns = 16'({9'h000, r[6:0]} * (r[7] ? RULE_COARSE_NS : RULE_FINE_NS));
	endfunction

	logic [15:0]  busy_en;
	logic [1:0]   clk_sel;
	logic [3:0]   bridge_key, super_key;
	logic [31:0]  presc;
	logic [7:0]   blk_thr, blk_pending;
	logic         drop_flag;
	logic [31:0]  rules;
	logic [7:0]   coin_win, inh_win;
	logic [8:0]   sec_delay;
	logic         coin_lvl_rd;
	logic [23:0]  sync_dly;
	logic [7:0]   rc_cnt [8];
	logic [31:0]  cap_ctrl;
	logic [23:0]  pin_s1, pin_s2;
	logic         ack_s3, ack_pend;
	logic [7:0]   src_local;
	logic [15:0]  busy_mon;

	// pins cross into the board clock through two flops
	always_ff @(posedge i_clk_sys)
	begin
		pin_s1 <= {i_fibre_ack, i_fibre_loss, i_fibre_busy, i_busy_pins};
		pin_s2 <= pin_s1;
		ack_s3 <= pin_s2[23];
	end

	wire logic       ack_rise = pin_s2[23] & ~ack_s3;
	wire logic [7:0] fib_busy = pin_s2[14:7];
	wire logic [7:0] fib_loss = pin_s2[22:15];

	// set wins over a same-cycle acknowledge
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			ack_pend <= 1'b0;
		else if (o_primary_trig)
			ack_pend <= 1'b1;
		else if (ack_rise)
			ack_pend <= 1'b0;
	end

	assign src_local = {pin_s2[6], ack_pend, pin_s2[5:0]};
	assign busy_mon = {fib_busy, src_local[7], |(fib_loss & busy_en[15:8]), src_local[5:0]};

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_busy <= 1'b0;
		else
			o_busy <= |({fib_busy, src_local} & busy_en);
	end

	// register writes; read-only fields have no storage here
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			busy_en <= 16'h0000;
			clk_sel <= CLK_SEL_RST;
			bridge_key <= 4'h0;
			super_key <= 4'h0;
			presc <= 32'h0000_0000;
			blk_thr <= BLK_THR_RST;
			rules <= {4{RULE_RST}};
			coin_win <= COIN_RST;
			inh_win <= INH_RST;
			sec_delay <= 9'h000;
			coin_lvl_rd <= 1'b0;
			o_panel_code_en <= 6'h00;
			o_panel_generic_en <= 16'h0000;
			o_panel_out <= 4'h0;
			sync_dly <= 24'h00_0000;
			o_panel_generic_prescale <= 24'h00_0000;
			cap_ctrl <= 32'h0000_FFFF;
		end
		else if (i_reg_wr)
		begin
			if (i_reg_addr == A_BUSY)
				busy_en <= i_reg_wdata[15:0];
			else if (i_reg_addr == A_CLK)
			begin
				clk_sel <= i_reg_wdata[1:0];
				bridge_key <= i_reg_wdata[19:16];
				super_key <= i_reg_wdata[23:20];
			end
			else if (i_reg_addr == A_PRESC)
				presc <= i_reg_wdata;
			else if (i_reg_addr == A_BLOCK)
				blk_thr <= i_reg_wdata[7:0];
			else if (i_reg_addr == A_RULES)
				rules <= i_reg_wdata;
			else if (i_reg_addr == A_COIN)
			begin
				coin_win <= i_reg_wdata[7:0];
				inh_win <= i_reg_wdata[15:8];
				sec_delay <= i_reg_wdata[24:16];
				coin_lvl_rd <= i_reg_wdata[31];
			end
			else if (i_reg_addr == A_CODE_EN)
				o_panel_code_en <= i_reg_wdata[5:0];
			else if (i_reg_addr == A_GEN_EN)
				o_panel_generic_en <= i_reg_wdata[15:0];
			else if (i_reg_addr == A_IRQBLK)
				o_panel_out <= i_reg_wdata[3:0];
			else if (i_reg_addr == A_SYNC)
				sync_dly <= i_reg_wdata[31:8];
			else if (i_reg_addr == A_GEN_PS)
				o_panel_generic_prescale <= i_reg_wdata[23:0];
			else if (i_reg_addr == A_CAP_ST)
				cap_ctrl <= i_reg_wdata;
		end
	end

	assign o_bridge_mode = (bridge_key == BRIDGE_KEY);
	assign o_supervisor_mode = (super_key == SUPER_KEY);
	// bridge mode takes its clock from fibre port one
	assign o_clk_sel = o_bridge_mode ? CLK_SEL_FIBRE1 : clk_sel;
	assign o_sync_delay_fibre1 = sync_dly[7:0];
	assign o_sync_delay_loop = sync_dly[15:8];
	assign o_sync_delay_fibre5 = sync_dly[23:16];

	// coincidence: first input opens window, later ones merge, then inhibit
	logic [7:0] coin_cnt, inh_cnt;
	logic       coin_panel, coin_pulse;
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			coin_cnt <= 8'h00;
			inh_cnt <= 8'h00;
			coin_panel <= 1'b0;
			coin_pulse <= 1'b0;
		end
		else
		begin
			coin_pulse <= 1'b0;
			if (coin_cnt != 8'h00)
			begin
				coin_cnt <= coin_cnt - 8'h01;
				coin_panel <= coin_panel | (i_trig_in & i_trig_panel);
				if (coin_cnt == 8'h01)
				begin
					coin_pulse <= 1'b1;
					inh_cnt <= inh_win;
				end
			end
			else if (inh_cnt != 8'h00)
				inh_cnt <= inh_cnt - 8'h01;
			else if (i_trig_in)
			begin
				coin_cnt <= (coin_win == 8'h00) ? 8'h01 : coin_win;
				coin_panel <= i_trig_panel;
			end
		end
	end

	// prescale, or multiply for panel triggers
	wire logic mul_mode = (presc[22:20] == MUL_KEY);
	logic [15:0] ps_cnt, burst_left;
	logic [12:0] sp_cnt;
	logic        ps_pulse;
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			ps_cnt <= 16'h0000;
			burst_left <= 16'h0000;
			sp_cnt <= 13'h0000;
			ps_pulse <= 1'b0;
		end
		else
		begin
			ps_pulse <= 1'b0;
			if (coin_pulse && mul_mode && coin_panel)
			begin
				burst_left <= 16'h0001 << presc[19:16];
				sp_cnt <= {presc[31:23], 4'h0};
			end
			else if (burst_left != 16'h0000)
			begin
				if (sp_cnt == 13'h1FFF)
				begin
					ps_pulse <= 1'b1;
					burst_left <= burst_left - 16'h0001;
					sp_cnt <= {presc[31:23], 4'h0};
				end
				else
					sp_cnt <= sp_cnt + 13'h0001;
			end
			else if (coin_pulse)
			begin
				if (ps_cnt >= presc[15:0])
				begin
					ps_pulse <= 1'b1;
					ps_cnt <= 16'h0000;
				end
				else
					ps_cnt <= ps_cnt + 16'h0001;
			end
		end
	end

	// secondary trigger builds a delayed primary
	logic        sec_run, sec_pulse;
	logic [15:0] sec_ns;
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			sec_run <= 1'b0;
			sec_ns <= 16'h0000;
			sec_pulse <= 1'b0;
		end
		else
		begin
			sec_pulse <= 1'b0;
			if (sec_run)
			begin
				sec_ns <= sec_ns + CLK_NS;
				if (sec_ns + CLK_NS >= SEC_OFFSET_NS + 16'({7'h00, sec_delay} * SEC_STEP_NS))
				begin
					sec_pulse <= 1'b1;
					sec_run <= 1'b0;
				end
			end
			else if (i_secondary_trig)
			begin
				sec_run <= 1'b1;
				sec_ns <= 16'h0000;
			end
		end
	end

	// spacing rules against the last four accepted trigger times
	logic [31:0] now_ns;
	logic [31:0] ts [4];
	logic [3:0]  ts_ok;
	logic        rules_ok, accept;
	always_comb
	begin
		rules_ok = 1'b1;
		for (int k = 0; k < 4; k++)
			if (ts_ok[k] && (now_ns - ts[k]) < {16'h0000, win_ns(rules[8*k +: 8])})
				rules_ok = 1'b0;
	end
	assign accept = (ps_pulse | sec_pulse) & rules_ok & (blk_pending < blk_thr);

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			now_ns <= 32'h0000_0000;
			ts_ok <= 4'h0;
			o_primary_trig <= 1'b0;
			for (int k = 0; k < 4; k++)
				ts[k] <= 32'h0000_0000;
		end
		else
		begin
			now_ns <= now_ns + {16'h0000, CLK_NS};
			o_primary_trig <= accept;
			if (accept)
			begin
				ts[0] <= now_ns;
				for (int k = 1; k < 4; k++)
					ts[k] <= ts[k-1];
				ts_ok <= {ts_ok[2:0], 1'b1};
			end
		end
	end

	// supervisor mode: secondary output is a one-cycle primary copy
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_secondary_trig <= 1'b0;
		else
			o_secondary_trig <= o_supervisor_mode ? accept : i_secondary_trig;
	end

	// block and readout counters
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			blk_pending <= 8'h00;
			drop_flag <= 1'b0;
			for (int i = 0; i < 8; i++)
				rc_cnt[i] <= 8'h00;
		end
		else
		begin
			blk_pending <= blk_pending + 8'(i_block_formed) - 8'(i_block_read);
			if (i_fifo_dropped)
				drop_flag <= 1'b1;
			for (int i = 0; i < 8; i++)
				rc_cnt[i] <= rc_cnt[i] + 8'(i_rc_sent) - 8'(i_rc_ack[i]);
		end
	end

	wire logic [4:0] evt_sat = (i_event_count > EVT_LIMIT) ? EVT_SAT : i_event_count[4:0];
	wire logic [2:0] irq_sat = (i_irq_waiting > IRQ_LIMIT) ? IRQ_SAT : i_irq_waiting[2:0];

	// debug capture, filled after the channel match
	tbc_cap_t          cap_state;
	logic [127:0]      cap_mem [CAP_DEPTH];
	logic [CAP_AW:0]   cap_wp, cap_rp;
	logic [15:0]       cap_reads;
	wire logic         cap_empty = (cap_wp == cap_rp);
	wire logic         cap_full = (cap_wp[CAP_AW] != cap_rp[CAP_AW]) &&
	                             (cap_wp[CAP_AW-1:0] == cap_rp[CAP_AW-1:0]);
	wire logic         cap_hit = &(cap_ctrl[15:0] | ~(i_cap_ch[95:80] ^ cap_ctrl[31:16]));
	wire logic         cap_pop = i_reg_rd && (i_reg_addr == A_CAP_ST) && !cap_empty;
	wire logic [127:0] cap_out = cap_mem[cap_rp[CAP_AW-1:0]];

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || (i_reg_wr && i_reg_addr == A_CAP_ST))
		begin
			cap_state <= CAP_ARM;
			cap_wp <= '0;
			cap_rp <= '0;
			cap_reads <= 16'h0000;
		end
		else
		begin
			case (cap_state)
				CAP_ARM:
					if (cap_hit)
						cap_state <= CAP_FILL;
				CAP_FILL:
					if (cap_full)
						cap_state <= CAP_DONE;
					else
					begin
						cap_mem[cap_wp[CAP_AW-1:0]] <= i_cap_ch;
						cap_wp <= cap_wp + 1'b1;
					end
				CAP_DONE:
					cap_state <= CAP_DONE;
				default:
					cap_state <= CAP_ARM;
			endcase
			if (cap_pop)
			begin
				cap_rp <= cap_rp + 1'b1;
				cap_reads <= cap_reads + 16'h0001;
			end
		end
	end

	// read decode; data captured before the pointer moves
	logic [31:0] next_rdata;
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (i_reg_addr == A_BUSY)
			next_rdata = {busy_mon, busy_en};
		else if (i_reg_addr == A_CLK)
			next_rdata = {8'h00, super_key, bridge_key, 14'h0000, clk_sel};
		else if (i_reg_addr == A_PRESC)
			next_rdata = presc;
		else if (i_reg_addr == A_BLOCK)
			next_rdata = {i_sync_event_busy, i_sync_reset_req, i_fill_active, i_run_stopped,
			              drop_flag, irq_sat, 3'h0, evt_sat, blk_pending, blk_thr};
		else if (i_reg_addr == A_RULES)
			next_rdata = rules;
		else if (i_reg_addr == A_COIN)
			next_rdata = {coin_lvl_rd, 6'h00, sec_delay, inh_win, coin_win};
		else if (i_reg_addr == A_CODE_EN)
			next_rdata = {26'h000_0000, o_panel_code_en};
		else if (i_reg_addr == A_GEN_EN)
			next_rdata = {16'h0000, o_panel_generic_en};
		else if (i_reg_addr == A_IRQBLK)
			next_rdata = {i_event_count, i_irq_waiting, blk_pending, 4'h0, o_panel_out};
		else if (i_reg_addr == A_SYNC)
			next_rdata = {sync_dly[23:16], i_sync_phase5, sync_dly[7:0], i_sync_phase1};
		else if (i_reg_addr == A_RC_LO)
			next_rdata = {rc_cnt[3], rc_cnt[2], rc_cnt[1], rc_cnt[0]};
		else if (i_reg_addr == A_RC_HI)
			next_rdata = {rc_cnt[7], rc_cnt[6], rc_cnt[5], rc_cnt[4]};
		else if (i_reg_addr == A_CAP_HI)
			next_rdata = cap_out[127:96];
		else if (i_reg_addr == A_GEN_PS)
			next_rdata = {8'h00, o_panel_generic_prescale};
		else if (i_reg_addr == A_CAP_ST)
			next_rdata = {cap_out[31:20], CAP_PATTERN, cap_reads};
		else if (i_reg_addr == A_CAP_MID)
			next_rdata = cap_out[63:32];
		else if (i_reg_addr == A_CAP_UP)
			next_rdata = cap_out[95:64];
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_reg_rdata <= 32'h0000_0000;
			o_reg_ack <= 1'b0;
		end
		else
		begin
			o_reg_ack <= i_reg_rd | i_reg_wr;
			if (i_reg_rd)
				o_reg_rdata <= next_rdata;
		end
	end

	chk_busy_gate_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(busy_en == 16'h0000) |=> !o_busy) else $error("busy with all sources off");
	chk_ack_pending: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_primary_trig |=> ack_pend) else $error("ack pending not set");
	chk_fibre_busy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		|(fib_busy & busy_en[15:8]) |=> o_busy) else $error("fibre busy lost");
	chk_bridge_clock: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(bridge_key == BRIDGE_KEY) |-> (o_clk_sel == CLK_SEL_FIBRE1)) else $error("bridge clk");
	chk_block_inhibit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(blk_pending >= blk_thr) |=> !o_primary_trig) else $error("trigger past inhibit");
	chk_drop_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_fifo_dropped |=> drop_flag [*3]) else $error("drop flag not sticky");
	chk_rule_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_primary_trig && (win_ns(rules[7:0]) > CLK_NS) |=> !o_primary_trig)
		else $error("spacing rule broken");
	chk_rc_count: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_rc_sent && !i_rc_ack[0]) |=> (rc_cnt[0] == $past(rc_cnt[0]) + 8'h01))
		else $error("controller count off");
	chk_cap_pop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_reg_rd && i_reg_addr == A_CAP_MID) |=> (cap_rp == $past(cap_rp)))
		else $error("capture moved on other read");
	chk_panel_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_reg_rd && i_reg_addr == A_IRQBLK) |=> (o_reg_rdata[7:0] == {4'h0, $past(o_panel_out)}))
		else $error("panel output readback wrong");
endmodule // tbc_regs

// ### tb/tbc_slave_model.sv
// fibre-linked slave board model: busy, trigger loss and acknowledge
module tbc_slave_model (
	// clock and trigger seen
	input  wire logic       i_clk_sys,
	input  wire logic       i_primary_trig,
	// stimulus from the bench
	input  wire logic [7:0] i_busy_req,
	input  wire logic [7:0] i_loss_req,
	input  int              i_ack_dly,
	// fibre side levels
	output logic      [7:0] o_fibre_busy,
	output logic      [7:0] o_fibre_loss,
	output logic            o_fibre_ack
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_fibre_ack = 1'b0;
	assign o_fibre_busy = i_busy_req;
	assign o_fibre_loss = i_loss_req;
	// late acks are the slow case; overlapping answers merge into one level
	always @(posedge i_clk_sys)
		if (i_primary_trig === 1'b1)
			fork
				begin
					repeat (i_ack_dly) @(posedge i_clk_sys);
					o_fibre_ack <= 1'b1;
					repeat (3) @(posedge i_clk_sys);
					o_fibre_ack <= 1'b0;
				end
			join_none
endmodule // tbc_slave_model

// ### tb/tb_trigger_busy_control_registers.sv
// self-checking bench for the trigger and busy control registers
module tb_trigger_busy_control_registers;
	timeunit 1ns;
	timeprecision 100ps;
	import tbc_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic [7:0]   addr = 8'h00;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic [31:0]  wdata = 32'h0000_0000;
	logic [31:0]  rdata;
	logic [6:0]   busy_pins = 7'h00;
	logic [7:0]   fbusy_req = 8'h00;
	logic [7:0]   floss_req = 8'h00;
	logic [7:0]   fbusy;
	logic [7:0]   floss;
	logic         fack;
	logic         busy;
	logic         ptrig;
	logic         strig;
	logic         trig = 1'b0;
	logic         panel = 1'b0;
	logic         sec = 1'b0;
	logic [7:0]   evt = 8'h00;
	logic [7:0]   irq = 8'h00;
	logic         blk_f = 1'b0;
	logic         blk_r = 1'b0;
	logic         drop = 1'b0;
	logic [3:0]   st = 4'h0;
	logic         rc_sent = 1'b0;
	logic [7:0]   rc_ack = 8'h00;
	logic [1:0]   csel;
	logic         bridge;
	logic         superv;
	logic [7:0]   d1;
	logic [7:0]   dl;
	logic [3:0]   pout;
	logic [7:0]   d5;
	logic [5:0]   code_en;
	logic [15:0]  gen_en;
	logic [23:0]  gen_ps;
	logic         ack;
	logic [127:0] cap = 128'h0123_4567_89AB_CDEF_F0E1_D2C3_B4A5_9687;
	logic [31:0]  v;
	logic [31:0]  w;
	int           ack_dly = 20;
	int           err_total = 0;
	int           check_count = 0;
	int           pcnt = 0;
	int           scnt = 0;
	logic [7:0]   ta [6] = '{A_RULES, A_RULES, A_COIN, A_PRESC, A_PRESC, A_COIN};
	logic [31:0]  tv [6] = '{32'h0303_0314, 32'h0303_0383, 32'h0000_000A, 32'h0000_0002,
		32'hFFD2_0000, 32'h0000_1402};
	logic [31:0]  tr [6] = '{32'h0303_0303, 32'h0303_0303, 32'h0000_0001, 32'h0, 32'h0,
		32'h0000_0001};
	int           tn [6] = '{2, 2, 2, 6, 1, 2};
	int           tg [6] = '{2, 8, 1, 20, 1, 6};
	int           te [6] = '{1, 1, 1, 2, 4, 1};

	tbc_slave_model slave (.i_clk_sys(clk), .i_primary_trig(ptrig), .i_busy_req(fbusy_req),
		.i_loss_req(floss_req), .i_ack_dly(ack_dly), .o_fibre_busy(fbusy),
		.o_fibre_loss(floss), .o_fibre_ack(fack));

	tbc_regs dut (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
		.i_busy_pins(busy_pins), .i_fibre_busy(fbusy), .i_fibre_loss(floss),
		.i_fibre_ack(fack), .o_busy(busy), .i_trig_in(trig), .i_trig_panel(panel),
		.i_secondary_trig(sec), .o_primary_trig(ptrig), .o_secondary_trig(strig),
		.o_clk_sel(csel), .o_bridge_mode(bridge), .o_supervisor_mode(superv),
		.i_block_formed(blk_f), .i_block_read(blk_r), .i_event_count(evt),
		.i_irq_waiting(irq), .i_fifo_dropped(drop), .i_run_stopped(st[0]),
		.i_fill_active(st[1]), .i_sync_reset_req(st[2]), .i_sync_event_busy(st[3]),
		.i_sync_phase1(8'h3C), .i_sync_phase5(8'hA5), .o_sync_delay_fibre1(d1),
		.o_sync_delay_loop(dl), .o_sync_delay_fibre5(d5), .i_rc_sent(rc_sent),
		.i_rc_ack(rc_ack), .o_panel_out(pout), .o_panel_code_en(code_en),
		.o_panel_generic_en(gen_en), .o_panel_generic_prescale(gen_ps), .i_cap_ch(cap));

	initial
	begin
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (ptrig === 1'b1)
			pcnt++;
		if (strig === 1'b1)
			scnt++;
	end

	task automatic results();
		if (err_total == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// inputs change 1 ns after the edge so sampling never races
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		cyc(1);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		cyc(1);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		d = rdata;
		chk(ack, 32'h0000_0001);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rreg(a, d);
		chk(d & m, e);
	endtask

	task automatic fire(input int n, input int gap);
		repeat (n)
		begin
			cyc(1);
			trig = 1'b1;
			cyc(1);
			trig = 1'b0;
			cyc(gap);
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	initial
	begin
		cyc(4);
		rst = 1'b0;
		rchk(A_CLK, 32'h00FF_0003, 32'h0);
		rchk(A_BLOCK, 32'h0000_00FF, 32'h01);
		rchk(A_RULES, 32'hFFFF_FFFF, 32'h0303_0303);
		rchk(A_COIN, 32'h0000_FFFF, 32'h0001);
		rchk(A_IRQBLK, 32'h0000_00FF, 32'h0);
		rchk(8'h00, 32'hFFFF_FFFF, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wreg(A_CLK, 32'(i));
			chk(csel, 32'(i));
		end
		wreg(A_CLK, 32'h0005_0001);
		chk({bridge, csel}, 32'h6);
		wreg(A_CLK, 32'h0070_0000);
		pcnt = 0;
		scnt = 0;
		fire(1, 30);
		chk({superv, pcnt[3:0], scnt[3:0]}, 32'h111);
		wreg(A_CLK, 32'h0);
		wreg(A_BUSY, 32'h0000_0101);
		busy_pins = 7'h01;
		cyc(5);
		chk(busy, 1);
		busy_pins = 7'h02;
		cyc(5);
		chk(busy, 0);
		fbusy_req = 8'h01;
		cyc(5);
		chk(busy, 1);
		fbusy_req = 8'h02;
		cyc(5);
		chk(busy, 0);
		for (int i = 0; i < 2; i++)
		begin
			floss_req = 8'(i + 1);
			cyc(5);
			rchk(A_BUSY, 32'h0040_0000, i ? 32'h0 : 32'h0040_0000);
		end
		floss_req = 8'h00;
		fbusy_req = 8'h00;
		wreg(A_BUSY, 32'h0000_0040);
		for (int i = 0; i < 2; i++)
		begin
			ack_dly = i ? 60 : 20;
			fire(1, 0);
			cyc(ack_dly - 10);
			chk(busy, 1);
			cyc(30);
			chk(busy, 0);
		end
		wreg(A_BUSY, 32'h0);
		for (int k = 0; k < 6; k++)
		begin
			wreg(ta[k], tv[k]);
			pcnt = 0;
			panel = (k == 4);
			fire(tn[k], tg[k]);
			cyc(100);
			chk(pcnt, te[k]);
			panel = 1'b0;
			wreg(ta[k], tr[k]);
			cyc(60);
		end
		pcnt = 0;
		sec = 1'b1;
		cyc(1);
		sec = 1'b0;
		cyc(48);
		chk(pcnt, 0);
		cyc(20);
		chk(pcnt, 1);
		blk_f = 1'b1;
		cyc(1);
		blk_f = 1'b0;
		cyc(3);
		rchk(A_BLOCK, 32'h0000_FF00, 32'h0100);
		pcnt = 0;
		fire(1, 10);
		chk(pcnt, 0);
		blk_r = 1'b1;
		cyc(1);
		blk_r = 1'b0;
		fire(1, 10);
		chk(pcnt, 1);
		for (int i = 0; i < 3; i++)
		begin
			evt = i ? (i == 1 ? 8'd31 : 8'd200) : 8'd30;
			irq = i ? (i == 1 ? 8'd7 : 8'd255) : 8'd6;
			cyc(3);
			rchk(A_BLOCK, 32'h071F_0000, i ? 32'h071F_0000 : 32'h061E_0000);
		end
		drop = 1'b1;
		cyc(1);
		drop = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			st = 4'((i < 4) ? (1 << i) : 0);
			cyc(5);
			rchk(A_BLOCK, 32'hF800_0000, 32'h0800_0000 | 32'(st) << 28);
		end
		wreg(A_IRQBLK, 32'hFFFF_FFFF);
		chk(pout, 32'hF);
		rchk(A_IRQBLK, 32'h0000_00FF, 32'h0F);
		wreg(A_CODE_EN, 32'hFFFF_FFFF);
		wreg(A_GEN_EN, 32'hFFFF_FFFF);
		wreg(A_GEN_PS, 32'hFFFF_FFFF);
		chk(code_en, 32'h0000_003F);
		chk(gen_en, 32'h0000_FFFF);
		chk(gen_ps, 32'h00FF_FFFF);
		rchk(A_CODE_EN, 32'hFFFF_FFFF, 32'h0000_003F);
		rchk(A_GEN_EN, 32'hFFFF_FFFF, 32'h0000_FFFF);
		rchk(A_GEN_PS, 32'hFFFF_FFFF, 32'h00FF_FFFF);
		wreg(A_SYNC, 32'h5ECD_AB00);
		chk({d5, dl, d1}, 32'h005E_CDAB);
		rchk(A_SYNC, 32'hFFFF_FFFF, 32'h5EA5_AB3C);
		repeat (2)
		begin
			cyc(1);
			rc_sent = 1'b1;
			cyc(1);
			rc_sent = 1'b0;
		end
		rc_ack = 8'h02;
		cyc(1);
		rc_ack = 8'h00;
		cyc(3);
		rchk(A_RC_LO, 32'h0000_FFFF, 32'h0102);
		wreg(A_RC_LO, 32'h0);
		rchk(A_RC_LO, 32'h0000_FFFF, 32'h0102);
		wreg(A_CAP_ST, {~cap[95:80], 16'h0000});
		cyc(20);
		rreg(A_CAP_ST, v);
		rreg(A_CAP_ST, w);
		chk(w[15:0], 16'h0000);
		wreg(A_CAP_ST, {cap[95:80], 16'h0000});
		cyc(20);
		rchk(A_CAP_HI, 32'hFFFF_FFFF, cap[127:96]);
		rchk(A_CAP_MID, 32'hFFFF_FFFF, cap[63:32]);
		rchk(A_CAP_UP, 32'hFFFF_FFFF, cap[95:64]);
		rreg(A_CAP_ST, v);
		chk(v, {cap[31:20], CAP_PATTERN, 16'h0000});
		rreg(A_CAP_ST, w);
		chk(w[15:0], 16'h0001);
		results();
	end
endmodule // tb_trigger_busy_control_registers
